// ---- hdl/ufmls_line_sync.sv ----
`timescale 1ns/10ps
module ufmls_line_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ufmls_line_sync

// ---- hdl/ufmls_pkg.sv ----
package ufmls_pkg;

  localparam int NUM_REGS = 18;

  // Register offsets, which are also pointer values
  localparam logic [4:0] OFS_MODE_A = 5'h00;
  localparam logic [4:0] OFS_MODE_B = 5'h01;
  localparam logic [4:0] OFS_LED0 = 5'h02;
  localparam logic [4:0] OFS_LED7 = 5'h09;
  localparam logic [4:0] OFS_GROUP_DUTY = 5'h0a;
  localparam logic [4:0] OFS_GROUP_PERIOD = 5'h0b;
  localparam logic [4:0] OFS_STATE_SEL_A = 5'h0c;
  localparam logic [4:0] OFS_STATE_SEL_B = 5'h0d;
  localparam logic [4:0] OFS_SUB_A = 5'h0e;
  localparam logic [4:0] OFS_SUB_B = 5'h0f;
  localparam logic [4:0] OFS_SUB_C = 5'h10;
  localparam logic [4:0] OFS_GROUP_ADDR = 5'h11;

  // Reset values
  localparam logic [7:0] RST_MODE_A = 8'h91;
  localparam logic [7:0] RST_MODE_B = 8'h05;
  localparam logic [7:0] RST_LED_DUTY = 8'h00;
  localparam logic [7:0] RST_GROUP_DUTY = 8'hff;
  localparam logic [7:0] RST_GROUP_PERIOD = 8'h00;
  localparam logic [7:0] RST_STATE_SEL = 8'h00;
  localparam logic [7:0] RST_SUB_A = 8'he2;
  localparam logic [7:0] RST_SUB_B = 8'he4;
  localparam logic [7:0] RST_SUB_C = 8'he8;
  localparam logic [7:0] RST_GROUP_ADDR = 8'he0;
  localparam logic [7:0] RST_CTRL = 8'h80;

  // Field positions
  localparam int CTRL_OPT_LSB = 5;
  localparam int MODE_A_SUB_A_BIT = 3;
  localparam int MODE_A_SUB_B_BIT = 2;
  localparam int MODE_A_SUB_C_BIT = 1;
  localparam int MODE_A_GROUP_BIT = 0;
  localparam int MODE_B_CHANGE_ACK_BIT = 3;

  // Address byte of the software reset call, operation bit included
  localparam logic [7:0] SOFT_RESET_ADDR_BYTE = 8'h06;

  // Increment options: enable, option hi, option lo
  localparam logic [2:0] INCR_ALL = 3'b100;
  localparam logic [2:0] INCR_LED = 3'b101;
  localparam logic [2:0] INCR_GROUP = 3'b110;
  localparam logic [2:0] INCR_MIX = 3'b111;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CTRL = 3'b011,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b110
  } ufmls_state_t;

  function automatic logic [7:0] ufmls_reset_val(input logic [4:0] idx);
    case (idx)
      OFS_MODE_A: ufmls_reset_val = RST_MODE_A;
      OFS_MODE_B: ufmls_reset_val = RST_MODE_B;
      OFS_GROUP_DUTY: ufmls_reset_val = RST_GROUP_DUTY;
      OFS_GROUP_PERIOD: ufmls_reset_val = RST_GROUP_PERIOD;
      OFS_STATE_SEL_A, OFS_STATE_SEL_B: ufmls_reset_val = RST_STATE_SEL;
      OFS_SUB_A: ufmls_reset_val = RST_SUB_A;
      OFS_SUB_B: ufmls_reset_val = RST_SUB_B;
      OFS_SUB_C: ufmls_reset_val = RST_SUB_C;
      OFS_GROUP_ADDR: ufmls_reset_val = RST_GROUP_ADDR;
      default: ufmls_reset_val = RST_LED_DUTY;
    endcase
  endfunction : ufmls_reset_val

endpackage : ufmls_pkg

// ---- hdl/ufmls_ptr_next.sv ----
`timescale 1ns/10ps
module ufmls_ptr_next import ufmls_pkg::*; (
  // Increment option bits and current pointer
  input wire logic [2:0] incr_mode,
  input wire logic [4:0] ptr,
  // Pointer after one data byte
  output logic [4:0] ptr_next
);

  logic [4:0] first;
  logic [4:0] last;

  assign first = (incr_mode == INCR_ALL) ? OFS_MODE_A :
                 (incr_mode == INCR_GROUP) ? OFS_GROUP_DUTY : OFS_LED0;
  assign last = (incr_mode == INCR_ALL) ? OFS_GROUP_ADDR :
                (incr_mode == INCR_LED) ? OFS_LED7 : OFS_GROUP_PERIOD;
  // Entry beyond the loop wraps at once rather than run into dead pointers
  assign ptr_next = !incr_mode[2] ? ptr :
                    (ptr >= last) ? first : ptr + 5'h01;

endmodule : ufmls_ptr_next

// ---- hdl/ufmls_slave.sv ----
`timescale 1ns/10ps
// Summary of operation
// RL1 - Master sends slave address after START
// RL2 - Regular address from six address pins
// RL3 - Last address bit selects; writes only
// RL4 - Reserved addresses matched like any other
// RL5 - Group call address E0h, enabled at reset
// RL6 - Three sub call addresses, disabled at reset
// RL7 - Soft reset only on byte 06h
// RL8 - First byte after match is control
// RL9 - Control holds pointer plus increment bits
// RL10 - Enabled increment advances pointer per byte
// RL11 - Option 100 wraps 11h to 00h
// RL12 - Option 101 wraps 09h to 02h
// RL13 - Option 110 wraps 0Bh to 0Ah
// RL14 - Option 111 wraps 0Bh to 02h
// RL15 - Option 000 keeps pointer fixed
// RL16 - Master never writes reserved options
// RL17 - Increment touches only pointer bits
// RL18 - Pointer entry anywhere 00h to 11h
// RL19 - Pointers 12h to 1Fh write nothing
module ufmls_slave import ufmls_pkg::*; #(
  parameter logic HW_ADDR_MSB = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Serial bus, driven by the master only
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  // Address strap pins
  input wire logic [5:0] hw_addr_pin,
  // Register contents
  output logic [7:0] reg_val [NUM_REGS],
  output logic [7:0] ctrl_byte,
  // Write events
  output logic reg_wr_pulse,
  output logic [4:0] reg_wr_index,
  output logic regs_commit,
  // Status
  output logic soft_reset_call,
  output logic frame_active
);

  logic scl_s;
  logic sda_s;
  logic [5:0] pins_s;
  logic scl_d_q;
  logic sda_d_q;
  ufmls_state_t st_q;
  ufmls_state_t st_d;
  logic [3:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] ctrl_q;
  logic [7:0] regs_q [NUM_REGS];
  logic [4:0] ptr_adv;
  logic soft_reset_q;
  logic wr_pulse_q;
  logic [4:0] wr_index_q;
  logic commit_q;
  logic ack_pending_q;

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic byte_done;
  logic ack_bit;
  logic [7:0] rx_byte;
  logic op_read;
  logic hit_regular;
  logic hit_group;
  logic hit_sub_a;
  logic hit_sub_b;
  logic hit_sub_c;
  logic hit_soft_reset;
  logic hit_any;
  logic ptr_valid;
  logic data_wr;
  logic [NUM_REGS-1:0] wr_en;

  ufmls_line_sync #(
    .WIDTH(2),
    .RST_VAL(2'b11)
  ) u_bus_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({serial_clock_line, serial_data_line}),
    .sync_out({scl_s, sda_s})
  );

  ufmls_line_sync #(
    .WIDTH(6),
    .RST_VAL(6'h00)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(hw_addr_pin),
    .sync_out(pins_s)
  );

  ufmls_ptr_next u_ptr_next (
    .incr_mode(ctrl_q[7:CTRL_OPT_LSB]),
    .ptr(ctrl_q[4:0]),
    .ptr_next(ptr_adv)
  );

  // Bus conditions, seen on the synchronised lines
  assign start_cond = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_cond = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign scl_rise = scl_s & ~scl_d_q;
  assign byte_done = scl_rise && (bit_cnt_q == 4'd7) && (st_q != ST_IDLE);
  // Ninth bit is always driven high by the master, never by us
  assign ack_bit = scl_rise && (bit_cnt_q == 4'd8) && (st_q != ST_IDLE);
  assign rx_byte = {shift_q, sda_s};
  assign op_read = rx_byte[0]; // [RL3]

  // Address compare; reserved codes get no special treatment
  assign hit_regular = (rx_byte[7:1] == {HW_ADDR_MSB, pins_s}); // [RL2] [RL4]
  assign hit_group = regs_q[OFS_MODE_A][MODE_A_GROUP_BIT] &&
                     (rx_byte[7:1] == regs_q[OFS_GROUP_ADDR][7:1]); // [RL5]
  assign hit_sub_a = regs_q[OFS_MODE_A][MODE_A_SUB_A_BIT] &&
                     (rx_byte[7:1] == regs_q[OFS_SUB_A][7:1]); // [RL6]
  assign hit_sub_b = regs_q[OFS_MODE_A][MODE_A_SUB_B_BIT] &&
                     (rx_byte[7:1] == regs_q[OFS_SUB_B][7:1]); // [RL6]
  assign hit_sub_c = regs_q[OFS_MODE_A][MODE_A_SUB_C_BIT] &&
                     (rx_byte[7:1] == regs_q[OFS_SUB_C][7:1]); // [RL6]
  assign hit_soft_reset = (rx_byte == SOFT_RESET_ADDR_BYTE); // [RL7]
  assign hit_any = hit_regular | hit_group | hit_sub_a | hit_sub_b | hit_sub_c;

  assign ptr_valid = (ctrl_q[4:0] <= OFS_GROUP_ADDR); // [RL18] [RL19]
  assign data_wr = byte_done && (st_q == ST_DATA) && ptr_valid;

  // Next state; a START anywhere restarts address reception
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: st_d = ST_IDLE;
      ST_ADDR: begin
        if (byte_done) begin
          // Soft reset code wins over a strap set to the same value
          if (op_read || hit_soft_reset || !hit_any) begin
            st_d = ST_SKIP; // [RL3] [RL7]
          end else begin
            st_d = ST_CTRL;
          end
        end
      end
      ST_CTRL: begin
        if (byte_done) begin
          st_d = ST_DATA; // [RL8]
        end
      end
      ST_DATA: st_d = ST_DATA;
      ST_SKIP: st_d = ST_SKIP;
      default: st_d = ST_IDLE;
    endcase
    if (start_cond) begin
      st_d = ST_ADDR; // [RL1]
    end else if (stop_cond) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      st_q <= st_d;
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // Bit counter runs 0..8; count 8 marks the ninth bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= 4'd0;
      shift_q <= 7'h00;
    end else if (start_cond) begin
      bit_cnt_q <= 4'd0;
    end else if (scl_rise) begin
      bit_cnt_q <= (bit_cnt_q == 4'd8) ? 4'd0 : bit_cnt_q + 4'd1;
      shift_q <= rx_byte[6:0];
    end
  end

  // Control byte; data bytes change only the pointer field
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= RST_CTRL;
    end else if (byte_done && st_q == ST_CTRL) begin
      ctrl_q <= rx_byte; // [RL8] [RL9]
    end else if (byte_done && st_q == ST_DATA) begin
      ctrl_q[4:0] <= ptr_adv; // [RL10] [RL11] [RL12] [RL13] [RL14] [RL15] [RL17]
    end
  end

  // Register file
  genvar g;
  for (g = 0; g < NUM_REGS; g++) begin : g_reg
    assign wr_en[g] = data_wr && (ctrl_q[4:0] == 5'(g)); // [RL19]
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        regs_q[g] <= ufmls_reset_val(5'(g));
      end else if (wr_en[g]) begin
        regs_q[g] <= rx_byte;
      end
    end
    // Top bits of the first mode register mirror the control byte
    if (g == 0) begin : g_mode
      assign reg_val[g] = {ctrl_q[7:CTRL_OPT_LSB], regs_q[g][CTRL_OPT_LSB-1:0]};
    end else begin : g_plain
      assign reg_val[g] = regs_q[g];
    end
  end

  // Event outputs; commit follows the ack bit or the STOP per mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      wr_index_q <= 5'h00;
      commit_q <= 1'b0;
      ack_pending_q <= 1'b0;
    end else begin
      soft_reset_q <= byte_done && (st_q == ST_ADDR) && hit_soft_reset; // [RL7]
      wr_pulse_q <= data_wr;
      if (data_wr) begin
        wr_index_q <= ctrl_q[4:0];
      end
      if (data_wr) begin
        ack_pending_q <= 1'b1;
      end else if (ack_bit || start_cond || stop_cond) begin
        ack_pending_q <= 1'b0;
      end
      commit_q <= regs_q[OFS_MODE_B][MODE_B_CHANGE_ACK_BIT] ?
                  (ack_bit && ack_pending_q) :
                  (stop_cond && st_q == ST_DATA);
    end
  end

  assign ctrl_byte = ctrl_q;
  assign soft_reset_call = soft_reset_q;
  assign reg_wr_pulse = wr_pulse_q;
  assign reg_wr_index = wr_index_q;
  assign regs_commit = commit_q;
  assign frame_active = (st_q != ST_IDLE);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_read_skipped: assert property ( // [RL3]
    byte_done && st_q == ST_ADDR && op_read && !start_cond && !stop_cond
    |=> st_q == ST_SKIP ##1 !reg_wr_pulse)
    else $error("read address not skipped");

  a_strap_match: assert property ( // [RL2]
    byte_done && st_q == ST_ADDR && !op_read && hit_regular && !hit_soft_reset
    && !start_cond && !stop_cond |=> st_q == ST_CTRL)
    else $error("strap address not accepted");

  a_soft_reset_byte: assert property ( // [RL7]
    soft_reset_call |-> $past(st_q) == ST_ADDR && $past(rx_byte) == 8'h06)
    else $error("soft reset pulse without its byte");

  a_ctrl_capture: assert property ( // [RL8]
    byte_done && st_q == ST_CTRL |=> ctrl_q == $past(rx_byte))
    else $error("control byte not stored");

  a_upper_kept: assert property ( // [RL17]
    st_q == ST_DATA |=> ctrl_q[7:5] == $past(ctrl_q[7:5]))
    else $error("increment bits changed during data");

  a_wrap_all: assert property ( // [RL11]
    byte_done && st_q == ST_DATA && ctrl_q[7:0] == 8'h91 |=> ctrl_q[4:0] == 5'h00)
    else $error("option 100 wrap wrong");

  a_wrap_led: assert property ( // [RL12]
    byte_done && st_q == ST_DATA && ctrl_q[7:0] == 8'ha9 |=> ctrl_q[4:0] == 5'h02)
    else $error("option 101 wrap wrong");

  a_wrap_group: assert property ( // [RL13]
    byte_done && st_q == ST_DATA && ctrl_q[7:0] == 8'hcb |=> ctrl_q[4:0] == 5'h0a)
    else $error("option 110 wrap wrong");

  a_wrap_mix: assert property ( // [RL14]
    byte_done && st_q == ST_DATA && ctrl_q[7:0] == 8'heb |=> ctrl_q[4:0] == 5'h02)
    else $error("option 111 wrap wrong");

  a_step_one: assert property ( // [RL10]
    byte_done && st_q == ST_DATA && ctrl_q[7] && ctrl_q[4:0] < 5'h09
    |=> ctrl_q[4:0] == $past(ctrl_q[4:0]) + 5'h01)
    else $error("pointer did not advance");

  a_ptr_fixed: assert property ( // [RL15]
    byte_done && st_q == ST_DATA && ctrl_q[7:5] == 3'b000 |=> $stable(ctrl_q[4:0]))
    else $error("pointer moved with increment off");

  a_dead_ptr: assert property ( // [RL19]
    byte_done && st_q == ST_DATA && ctrl_q[4:0] > 5'h11 |=> !reg_wr_pulse)
    else $error("write to unrecognised pointer");

  // Stored copy, since the port shows control bits on top of register 0
  a_write_lands: assert property ( // [RL18]
    data_wr |=> reg_wr_pulse && regs_q[reg_wr_index] == $past(rx_byte))
    else $error("data byte not stored at pointer");

  a_group_match: assert property ( // [RL5]
    byte_done && st_q == ST_ADDR && !op_read && hit_group && !hit_soft_reset
    && !start_cond && !stop_cond |=> st_q == ST_CTRL)
    else $error("group call address not accepted");

  a_sub_match: assert property ( // [RL6]
    byte_done && st_q == ST_ADDR && !op_read && (hit_sub_a || hit_sub_b || hit_sub_c)
    && !hit_soft_reset && !start_cond && !stop_cond |=> st_q == ST_CTRL)
    else $error("sub call address not accepted");

  a_soft_reset_only: assert property ( // [RL7]
    byte_done && st_q == ST_ADDR && rx_byte != SOFT_RESET_ADDR_BYTE |=> !soft_reset_call)
    else $error("soft reset pulse on another byte");

  a_soft_reset_skip: assert property ( // [RL7]
    byte_done && st_q == ST_ADDR && hit_soft_reset && !start_cond && !stop_cond
    |=> st_q == ST_SKIP)
    else $error("soft reset frame not skipped");

  a_ctrl_then_data: assert property ( // [RL8]
    byte_done && st_q == ST_CTRL && !start_cond && !stop_cond |=> st_q == ST_DATA)
    else $error("no data phase after control byte");

  a_ctrl_hold: assert property ( // [RL17]
    !(byte_done && (st_q == ST_CTRL || st_q == ST_DATA)) |=> $stable(ctrl_q))
    else $error("control byte changed without a byte");

  a_data_only: assert property ( // [RL8]
    reg_wr_pulse |-> $past(st_q) == ST_DATA)
    else $error("register write outside data phase");

  a_entry_write: assert property ( // [RL18]
    byte_done && st_q == ST_DATA && ctrl_q[4:0] <= OFS_GROUP_ADDR
    |=> reg_wr_pulse && reg_wr_index == $past(ctrl_q[4:0]))
    else $error("data byte not sent to pointer");

  c_soft_reset: cover property (soft_reset_call);
  c_group_call: cover property (byte_done && st_q == ST_ADDR && hit_group);
  c_wrap_all: cover property (data_wr && ctrl_q[7:0] == 8'h91);
  c_commit: cover property (regs_commit);
  c_ack_commit: cover property (regs_commit && regs_q[OFS_MODE_B][MODE_B_CHANGE_ACK_BIT]);

endmodule : ufmls_slave

// ---- verif/ufmls_master.sv ----
`timescale 1ns/10ps
module ufmls_master (
  // Clock
  input wire logic clk_sys,
  // Bus lines, driven only here; idle high as with a pull-up
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Data moves mid-low so no edge ever looks like START or STOP
  task automatic bit_out(input logic b);
    sda <= b;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    scl <= 1'b0;
    cyc(2);
  endtask : bit_out

  // Clock stands high outside frames
  task automatic start();
    sda <= 1'b1;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda <= 1'b0;
    cyc(4);
    scl <= 1'b0;
    cyc(2);
  endtask : start

  task automatic stop();
    sda <= 1'b0;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda <= 1'b1;
    cyc(4);
  endtask : stop

  // Caller sends the address as the first byte after start
  task automatic send_byte(input logic [7:0] b);
    int i;
    for (i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_out(1'b1);
  endtask : send_byte
endmodule : ufmls_master

// ---- verif/ufmls_slave_tb_top.sv ----
`timescale 1ns/10ps
module ufmls_slave_tb_top import ufmls_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] hw_addr_pin = 6'h04;
  wire logic scl;
  wire logic sda;
  logic [7:0] reg_val [NUM_REGS];
  logic [7:0] ctrl_byte;
  logic reg_wr_pulse;
  logic [4:0] reg_wr_index;
  logic regs_commit;
  logic soft_reset_call;
  logic frame_active;
  int errors = 0;
  int tests_run = 0;
  int n_wr = 0;
  int n_sr = 0;
  int e_wr = 0;
  int e_sr = 0;
  int n_cm = 0;
  int e_cm = 0;
  logic [7:0] exp_reg [NUM_REGS] = '{8'h91, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'he2, 8'he4, 8'he8, 8'he0};
  logic [7:0] exp_ctrl = 8'h80;
  logic [4:0] exp_idx = 5'h00;

  always #25 clk_sys = ~clk_sys;

  ufmls_master i_ufmls_master (.clk_sys(clk_sys), .scl(scl), .sda(sda));

  ufmls_slave i_ufmls_slave (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .serial_clock_line(scl),
    .serial_data_line(sda),
    .hw_addr_pin(hw_addr_pin),
    .reg_val(reg_val),
    .ctrl_byte(ctrl_byte),
    .reg_wr_pulse(reg_wr_pulse),
    .reg_wr_index(reg_wr_index),
    .regs_commit(regs_commit),
    .soft_reset_call(soft_reset_call),
    .frame_active(frame_active)
  );

  always @(posedge clk_sys) begin
    if (reg_wr_pulse === 1'b1) n_wr++;
    if (soft_reset_call === 1'b1) n_sr++;
    if (regs_commit === 1'b1) n_cm++;
  end

  function automatic logic [4:0] nxt(input logic [2:0] o, input logic [4:0] p);
    case (o)
      3'b100: nxt = (p >= 5'h11) ? 5'h00 : p + 5'h01;
      3'b101: nxt = (p >= 5'h09) ? 5'h02 : p + 5'h01;
      3'b110: nxt = (p >= 5'h0b) ? 5'h0a : p + 5'h01;
      3'b111: nxt = (p >= 5'h0b) ? 5'h02 : p + 5'h01;
      default: nxt = p;
    endcase
  endfunction : nxt

  // Soft reset byte wins over any equal address
  function automatic logic hit(input logic [7:0] a);
    hit = !a[0] && a != 8'h06 && (a[7:1] == {1'b0, hw_addr_pin}
      || (exp_reg[0][0] && a[7:1] == exp_reg[17][7:1])
      || (exp_reg[0][3] && a[7:1] == exp_reg[14][7:1])
      || (exp_reg[0][2] && a[7:1] == exp_reg[15][7:1])
      || (exp_reg[0][1] && a[7:1] == exp_reg[16][7:1]));
  endfunction : hit

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk_cnt(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt

  task automatic check_all();
    int k;
    for (k = 0; k < NUM_REGS; k++) begin
      chk8("reg_val", (k == 0) ? {exp_ctrl[7:5], exp_reg[0][4:0]} : exp_reg[k], reg_val[k]);
    end
    chk8("ctrl_byte", exp_ctrl, ctrl_byte);
    if (e_wr > 0) chk8("reg_wr_index", {3'b000, exp_idx}, {3'b000, reg_wr_index});
    chk_cnt("writes", e_wr, n_wr);
    chk_cnt("soft_resets", e_sr, n_sr);
    chk_cnt("commits", e_cm, n_cm);
    chk8("frame_active", 8'h00, {7'h00, frame_active});
  endtask : check_all

  // Unmatched frames still carry control and data, which must be ignored
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input int n,
                      input logic [7:0] d);
    logic m;
    logic [4:0] p;
    int i;
    m = hit(a);
    p = c[4:0];
    i_ufmls_master.start();
    chk8("frame_active", 8'h01, {7'h00, frame_active});
    i_ufmls_master.send_byte(a);
    i_ufmls_master.send_byte(c);
    for (i = 0; i < n; i++) begin
      i_ufmls_master.send_byte(d + 8'(i));
      if (m && p <= 5'h11) begin
        exp_reg[p] = d + 8'(i);
        exp_idx = p;
        e_wr++;
        // Commit on the ninth bit once the written byte has taken effect
        if (exp_reg[OFS_MODE_B][MODE_B_CHANGE_ACK_BIT]) e_cm++;
      end
      p = nxt(c[7:5], p);
    end
    i_ufmls_master.stop();
    if (m) exp_ctrl = {c[7:5], p};
    if (m && !exp_reg[OFS_MODE_B][MODE_B_CHANGE_ACK_BIT]) e_cm++;
    if (a == 8'h06) e_sr++;
    repeat (10) @(posedge clk_sys);
    check_all();
  endtask : xfer

  task automatic final_report();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // Options 001 to 011 are never sent
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check_all();
    xfer(8'h08, 8'h8f, 5, 8'hc0);
    xfer(8'hc2, 8'ha8, 4, 8'h10);
    xfer(8'hc0, 8'hca, 3, 8'h20);
    xfer(8'he2, 8'h82, 2, 8'h30);
    xfer(8'h08, 8'heb, 3, 8'h40);
    xfer(8'h08, 8'h05, 3, 8'h50);
    xfer(8'h08, 8'h12, 2, 8'h60);
    xfer(8'h08, 8'h9f, 2, 8'h70);
    xfer(8'h08, 8'h01, 1, 8'h0d);
    xfer(8'h08, 8'h84, 2, 8'hd0);
    xfer(8'h09, 8'h84, 1, 8'h80);
    xfer(8'h06, 8'h84, 1, 8'h90);
    xfer(8'h07, 8'h84, 1, 8'ha0);
    xfer(8'he0, 8'h84, 1, 8'hb0);
    final_report();
  end

  // Whole sequence takes well under 10000 cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    final_report();
  end
endmodule : ufmls_slave_tb_top
